// >>> inc/pft_pkg.sv
// Constants and types for the program flash table access block
// Overview of operation
// - Serial programming over clock, data and clear
// - Self-programming driven by table read/write
// - Erase clears one 32-instruction row only
// - Write programs one full 32-word row
// - Low table ops move bits 15:0
// - High table ops move bits 23:16
// - Word or byte size chosen per op
// - Address is page byte plus effective address
// - Start bit 15 self-clears when done
// - Row address captures last table EA 15:0
package pft_pkg;
  localparam int unsigned WORD_W    = 24;
  localparam int unsigned ROW_WORDS = 32;
  localparam int unsigned ROW_BITS  = 5;
  localparam int unsigned MEM_AW    = 10;
  localparam int unsigned MEM_DEPTH = 1024;
  localparam int unsigned CLK_MHZ   = 200;
  localparam int unsigned PROG_TIME_US  = 2000;
  localparam int unsigned PROG_CYCLES   = PROG_TIME_US * CLK_MHZ;
  // Register byte addresses
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_ROWADR = 8'h04;
  localparam logic [7:0] ADDR_ROWADU = 8'h08;
  localparam logic [7:0] ADDR_KEY    = 8'h0c;
  localparam logic [7:0] ADDR_PAGE   = 8'h10;
  localparam logic [7:0] ADDR_TBLEA  = 8'h14;
  localparam logic [7:0] ADDR_TBLDAT = 8'h18;
  localparam logic [7:0] ADDR_TBLCMD = 8'h1c;
  // Control fields
  localparam int unsigned CTRL_START = 15;
  localparam int unsigned CTRL_WREN  = 14;
  localparam int unsigned CTRL_ERR   = 13;
  localparam int unsigned CTRL_ERASE = 6;
  // Command register fields
  localparam int unsigned CMD_GO    = 0;
  localparam int unsigned CMD_WRITE = 1;
  localparam int unsigned CMD_HIGH  = 2;
  localparam int unsigned CMD_BYTE  = 3;
  localparam int unsigned CMD_BSEL  = 4;
  localparam logic [7:0] KEY_FIRST  = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'haa;
  localparam logic [WORD_W-1:0] ERASED = 24'hffffff;
  typedef enum logic [3:0] {
    PFT_IDLE  = 4'b0001,
    PFT_ERASE = 4'b0010,
    PFT_PROG  = 4'b0100,
    PFT_WAIT  = 4'b1000
  } pft_state_e;
endpackage : pft_pkg

// >>> hw/pft_mem.sv
// Flash array store with registered read data
`timescale 1ns/1ps
module pft_mem
  import pft_pkg::*;
(
  input  wire logic              hclk,
  input  wire logic              we,
  input  wire logic [MEM_AW-1:0] waddr,
  input  wire logic [WORD_W-1:0] wdata,
  input  wire logic [MEM_AW-1:0] raddr,
  output logic      [WORD_W-1:0] rdata
);
  logic [WORD_W-1:0] mem [MEM_DEPTH];

  always_ff @(posedge hclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule : pft_mem

// >>> hw/pft_top.sv
// Program flash table access engine with AHB-Lite registers
`timescale 1ns/1ps
module pft_top
  import pft_pkg::*;
#(
  parameter int unsigned PROG_CYC = PROG_CYCLES
)(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        prog_clock_line,
  input  wire logic        prog_data_line_in,
  output logic             prog_data_line_out,
  output logic             prog_data_line_oe_n,
  input  wire logic        master_clear_line_n,
  output logic             flash_busy
);
  ////////////////////////////////////////////////////////////////////////////
  // Bus address phase capture
  logic        ap_valid;
  logic        ap_write;
  logic [7:0]  ap_addr;
  wire         take = hsel && htrans[1] && hready;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_valid <= 1'b0;
      ap_write <= 1'b0;
      ap_addr  <= 8'h00;
    end else begin
      ap_valid <= take;
      ap_write <= hwrite;
      ap_addr  <= haddr[7:0];
    end
  end

  wire wr_ctrl   = ap_valid && ap_write && (ap_addr == ADDR_CTRL);
  wire wr_rowadr = ap_valid && ap_write && (ap_addr == ADDR_ROWADR);
  wire wr_rowadu = ap_valid && ap_write && (ap_addr == ADDR_ROWADU);
  wire wr_key    = ap_valid && ap_write && (ap_addr == ADDR_KEY);
  wire wr_page   = ap_valid && ap_write && (ap_addr == ADDR_PAGE);
  wire wr_tblea  = ap_valid && ap_write && (ap_addr == ADDR_TBLEA);
  wire wr_tbldat = ap_valid && ap_write && (ap_addr == ADDR_TBLDAT);
  wire wr_tblcmd = ap_valid && ap_write && (ap_addr == ADDR_TBLCMD);

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [15:0]        ctrl;
  logic [15:0]        row_adr;
  logic [7:0]         row_adu;
  logic [7:0]         table_page_register;
  logic [15:0]        tbl_ea;
  logic [15:0]        tbl_wdat;
  logic [15:0]        tbl_rdat;
  logic               key_half;
  logic               unlocked;
  pft_state_e         state;
  logic [31:0]        cnt;
  logic [ROW_BITS-1:0] idx;
  logic [WORD_W-1:0]  latch [ROW_WORDS];

  // Serial programming pins, two-flop synchronised
  logic [1:0] pgc_s;
  logic [1:0] pgd_s;
  logic [1:0] master_clear_line_s;
  logic       pgc_d;
  logic [WORD_W-1:0] ser_sh;
  logic [4:0] ser_cnt;
  wire        ser_mode = !master_clear_line_s[1];
  wire        pgc_rise = pgc_s[1] && !pgc_d;

  ////////////////////////////////////////////////////////////////////////////
  // Table operation decode
  wire        cmd_go    = wr_tblcmd && hwdata[CMD_GO] && (state == PFT_IDLE);
  wire        cmd_write = hwdata[CMD_WRITE];
  wire        cmd_high  = hwdata[CMD_HIGH];
  wire        cmd_byte  = hwdata[CMD_BYTE];
  wire        cmd_bsel  = hwdata[CMD_BSEL];
  wire        byte_hi   = cmd_bsel | tbl_ea[0];
  wire [23:0] full_addr = {table_page_register, tbl_ea};
  wire [ROW_BITS-1:0] lidx = full_addr[ROW_BITS:1];
  wire [WORD_W-1:0] lcur = latch[lidx];

  function automatic logic [WORD_W-1:0] merge_word(input logic [WORD_W-1:0] old,
      input logic high, input logic bsz, input logic bhi, input logic [15:0] d);
    logic [WORD_W-1:0] w;
    w = old;
    if (high) begin
      w[23:16] = d[7:0];
    end else if (!bsz) begin
      w[15:0] = d;
    end else if (bhi) begin
      w[15:8] = d[7:0];
    end else begin
      w[7:0] = d[7:0];
    end
    return w;
  endfunction : merge_word

  ////////////////////////////////////////////////////////////////////////////
  // Flash array port
  logic              mem_we;
  logic [MEM_AW-1:0] mem_waddr;
  logic [WORD_W-1:0] mem_wdata;
  logic [WORD_W-1:0] mem_rdata;
  logic              rd_pend;
  logic              rd_high;
  logic              rd_byte;
  logic              rd_bhi;
  wire [MEM_AW-1:0]  row_base = {row_adr[MEM_AW:ROW_BITS+1], {ROW_BITS{1'b0}}};
  wire [MEM_AW-1:0]  rd_addr  = full_addr[MEM_AW:1];

  always_comb begin
    mem_we    = 1'b0;
    mem_waddr = row_base | MEM_AW'(idx);
    mem_wdata = ERASED;
    if (state == PFT_ERASE) begin
      mem_we = 1'b1;
    end else if (state == PFT_PROG) begin
      mem_we    = 1'b1;
      mem_wdata = latch[idx];
    end else if (ser_mode && ser_cnt == 5'(WORD_W)) begin
      mem_we    = 1'b1;
      mem_waddr = row_adr[MEM_AW:1];
      mem_wdata = ser_sh;
    end
  end

  pft_mem u_mem (
    .hclk  (hclk),
    .we    (mem_we),
    .waddr (mem_waddr),
    .wdata (mem_wdata),
    .raddr (rd_addr),
    .rdata (mem_rdata)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Holding latches, only table writes load them
  always_ff @(posedge hclk) begin
    if (cmd_go && cmd_write) begin
      latch[lidx] <= merge_word(lcur, cmd_high, cmd_byte, byte_hi, tbl_wdat);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control, key sequence and programming timer
  wire start_req = wr_ctrl && hwdata[CTRL_START] && unlocked && ctrl[CTRL_WREN];
  wire done_tick = (state == PFT_WAIT) && (cnt == 32'(PROG_CYC - 1));

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl     <= 16'h0000;
      row_adr  <= 16'h0000;
      row_adu  <= 8'h00;
      table_page_register <= 8'h00;
      tbl_ea   <= 16'h0000;
      tbl_wdat <= 16'h0000;
      tbl_rdat <= 16'h0000;
      key_half <= 1'b0;
      unlocked <= 1'b0;
      state    <= PFT_IDLE;
      cnt      <= 32'h0;
      idx      <= '0;
      rd_pend  <= 1'b0;
      rd_high  <= 1'b0;
      rd_byte  <= 1'b0;
      rd_bhi   <= 1'b0;
    end else begin
      rd_pend <= cmd_go && !cmd_write;
      if (cmd_go) begin
        rd_high <= cmd_high;
        rd_byte <= cmd_byte;
        rd_bhi  <= byte_hi;
        row_adr <= tbl_ea;
        row_adu <= table_page_register;
      end else if (wr_rowadr) begin
        row_adr <= hwdata[15:0];
      end else if (wr_rowadu) begin
        row_adu <= hwdata[7:0];
      end
      if (rd_pend) begin
        if (rd_high) begin
          tbl_rdat <= {8'h00, mem_rdata[23:16]};
        end else if (!rd_byte) begin
          tbl_rdat <= mem_rdata[15:0];
        end else begin
          tbl_rdat <= {8'h00, rd_bhi ? mem_rdata[15:8] : mem_rdata[7:0]};
        end
      end
      if (wr_page) table_page_register <= hwdata[7:0];
      if (wr_tblea) tbl_ea <= hwdata[15:0];
      if (wr_tbldat) tbl_wdat <= hwdata[15:0];
      // Two keys in consecutive bus writes arm one start
      if (ap_valid && ap_write) begin
        key_half <= wr_key && (hwdata[7:0] == KEY_FIRST);
        unlocked <= key_half && wr_key && (hwdata[7:0] == KEY_SECOND);
      end
      if (wr_ctrl && state == PFT_IDLE) begin
        ctrl <= {start_req, hwdata[14:0]};
      end
      case (state)
        PFT_IDLE: begin
          if (start_req) begin
            idx   <= '0;
            state <= hwdata[CTRL_ERASE] ? PFT_ERASE : PFT_PROG;
          end
        end
        PFT_ERASE, PFT_PROG: begin
          idx <= idx + 1'b1;
          if (idx == ROW_BITS'(ROW_WORDS - 1)) begin
            cnt   <= 32'h0;
            state <= PFT_WAIT;
          end
        end
        PFT_WAIT: begin
          cnt <= cnt + 32'h1;
          if (done_tick) begin
            ctrl[CTRL_START] <= 1'b0;
            state <= PFT_IDLE;
          end
        end
        default: state <= PFT_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Serial programming: 24 bits shifted on rising clock edges
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pgc_s   <= 2'b00;
      pgd_s   <= 2'b00;
      master_clear_line_s  <= 2'b11;
      pgc_d   <= 1'b0;
      ser_sh  <= '0;
      ser_cnt <= 5'h0;
    end else begin
      pgc_s  <= {pgc_s[0], prog_clock_line};
      pgd_s  <= {pgd_s[0], prog_data_line_in};
      master_clear_line_s <= {master_clear_line_s[0], master_clear_line_n};
      pgc_d  <= pgc_s[1];
      if (!ser_mode || ser_cnt == 5'(WORD_W)) begin
        ser_cnt <= 5'h0;
      end else if (pgc_rise) begin
        ser_sh  <= {ser_sh[WORD_W-2:0], pgd_s[1]};
        ser_cnt <= ser_cnt + 5'h1;
      end
    end
  end

  assign prog_data_line_out = 1'b0;
  assign prog_data_line_oe_n = 1'b1;
  assign flash_busy = (state != PFT_IDLE);

  ////////////////////////////////////////////////////////////////////////////
  // Read mux and bus response
  wire [31:0] rd_mux =
    (haddr[7:0] == ADDR_CTRL)   ? {16'h0000, ctrl} :
    (haddr[7:0] == ADDR_ROWADR) ? {16'h0000, row_adr} :
    (haddr[7:0] == ADDR_ROWADU) ? {24'h000000, row_adu} :
    (haddr[7:0] == ADDR_PAGE)   ? {24'h000000, table_page_register} :
    (haddr[7:0] == ADDR_TBLEA)  ? {16'h0000, tbl_ea} :
    (haddr[7:0] == ADDR_TBLDAT) ? {16'h0000, tbl_rdat} :
    (haddr[7:0] == ADDR_TBLCMD) ? {31'h0, rd_pend} : 32'h0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0;
    end else if (take && !hwrite) begin
      hrdata <= rd_mux;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
endmodule : pft_top

// >>> tb/pft_top_asserts.sv
// Port checker for the table access block
`timescale 1ns/1ps
module pft_top_asserts
  import pft_pkg::*;
#(
  parameter int unsigned PROG_CYC = PROG_CYCLES
)(
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        prog_data_line_oe_n,
  input wire logic        flash_busy
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic        dp_wr;
  logic        dp_rd;
  logic [7:0]  dp_a;
  logic [31:0] busy_cnt;
  wire start_wr = dp_wr && dp_a == ADDR_CTRL && hwdata[CTRL_START];
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_wr    <= 1'b0;
      dp_rd    <= 1'b0;
      dp_a     <= '0;
      busy_cnt <= '0;
    end else begin
      dp_wr    <= hsel && htrans[1] && hready && hwrite;
      dp_rd    <= hsel && htrans[1] && hready && !hwrite;
      dp_a     <= haddr[7:0];
      busy_cnt <= flash_busy ? busy_cnt + 1 : '0;
    end
  end
  sequence key_s(logic [7:0] k);
    dp_wr && dp_a == ADDR_KEY && hwdata[7:0] == k;
  endsequence
  sequence unlock_s;
    key_s(KEY_FIRST) ##2 key_s(KEY_SECOND);
  endsequence
  ready_always_a: assert property (hreadyout) else $error("wait state seen");
  resp_okay_a: assert property (!hresp) else $error("error response seen");
  pin_released_a: assert property (prog_data_line_oe_n) else $error("data pin driven");
  unlock_start_a: assert property (unlock_s ##2 (start_wr && hwdata[CTRL_WREN] && !flash_busy)
    |-> ##[1:3] flash_busy) else $error("unlocked start ignored");
  start_cause_a: assert property ($rose(flash_busy) |-> $past(start_wr) || $past(start_wr, 2))
    else $error("busy without start");
  busy_len_a: assert property ($fell(flash_busy) |-> busy_cnt >= ROW_WORDS + PROG_CYC - 1
    && busy_cnt <= ROW_WORDS + PROG_CYC + 2) else $error("busy length off");
  start_bit_a: assert property (dp_rd && dp_a == ADDR_CTRL && $past(flash_busy) == flash_busy
    |-> hrdata[CTRL_START] == flash_busy) else $error("start bit mismatch");
  key_hidden_a: assert property (dp_rd && dp_a == ADDR_KEY |-> hrdata == '0)
    else $error("key readable");
  unmapped_zero_a: assert property (dp_rd && dp_a >= 8'h20 |-> hrdata == '0)
    else $error("unmapped read nonzero");
endmodule : pft_top_asserts

bind pft_top pft_top_asserts #(.PROG_CYC(PROG_CYC)) u_pft_top_asserts (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .prog_data_line_oe_n(prog_data_line_oe_n),
  .flash_busy(flash_busy));

// >>> tb/pft_serial_model.sv
// Serial programmer model driving clock, data and clear
`timescale 1ns/1ps
module pft_serial_model (
  output logic prog_clock_line,
  output logic prog_data_line_in,
  output logic master_clear_line_n
);
  initial begin
    prog_clock_line     = 1'b0;
    prog_data_line_in   = 1'b1;
    master_clear_line_n = 1'b1;
  end
  // Clock idles low between frames, data is inverted after
  task automatic send(input logic [23:0] w);
    master_clear_line_n = 1'b0;
    #50;
    for (int i = 23; i >= 0; i--) begin
      prog_data_line_in = w[i];
      #40 prog_clock_line = 1'b1;
      #40 prog_clock_line = 1'b0;
    end
    prog_data_line_in = ~prog_data_line_in;
    #50 master_clear_line_n = 1'b1;
  endtask : send
endmodule : pft_serial_model

// >>> tb/pft_top_bench.sv
// Self-checking bench for the table access block
`timescale 1ns/1ps
module pft_top_bench;
  import pft_pkg::*;
  logic        hclk    = 1'b0;
  logic        hresetn = 1'b0;
  logic        hwrite  = 1'b0;
  logic [1:0]  htrans  = '0;
  logic [31:0] haddr   = '0;
  logic [31:0] hwdata  = '0;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic        hreadyout;
  logic        hresp;
  logic        flash_busy;
  logic        prog_clock_line;
  logic        prog_data_line_in;
  logic        master_clear_line_n;
  logic        prog_data_line_out;
  logic        prog_data_line_oe_n;
  int          num_errors = 0;
  int          checked    = 0;
  always #2.5 hclk = ~hclk;
  pft_top #(.PROG_CYC(8)) u_pft_top (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .prog_clock_line(prog_clock_line), .prog_data_line_in(prog_data_line_in),
    .prog_data_line_out(prog_data_line_out), .prog_data_line_oe_n(prog_data_line_oe_n),
    .master_clear_line_n(master_clear_line_n), .flash_busy(flash_busy));
  pft_serial_model u_pft_serial_model (.prog_clock_line(prog_clock_line),
    .prog_data_line_in(prog_data_line_in), .master_clear_line_n(master_clear_line_n));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    haddr  <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : xfer
  task automatic tbl_wrc(input logic [15:0] ea, input logic [31:0] cmd, input logic [31:0] d);
    xfer(1'b1, ADDR_TBLEA, {16'h0, ea});
    xfer(1'b1, ADDR_TBLDAT, d);
    xfer(1'b1, ADDR_TBLCMD, cmd);
  endtask : tbl_wrc
  task automatic tbl_wr(input logic [15:0] ea, input logic hi, input logic [31:0] d);
    tbl_wrc(ea, hi ? 32'h7 : 32'h3, d);
  endtask : tbl_wr
  task automatic tbl_rdc(input logic [15:0] ea, input logic [31:0] cmd, input logic [31:0] exp);
    xfer(1'b1, ADDR_TBLEA, {16'h0, ea});
    xfer(1'b1, ADDR_TBLCMD, cmd);
    xfer(1'b0, ADDR_CTRL, 32'h0);
    xfer(1'b0, ADDR_TBLDAT, 32'h0);
    chk("table read", exp, rd);
  endtask : tbl_rdc
  task automatic tbl_rd(input logic [15:0] ea, input logic hi, input logic [31:0] exp);
    tbl_rdc(ea, hi ? 32'h5 : 32'h1, exp);
  endtask : tbl_rd
  task automatic start(input logic [31:0] ctrl);
    xfer(1'b1, ADDR_CTRL, ctrl & 32'h7fff);
    xfer(1'b1, ADDR_KEY, 32'h55);
    xfer(1'b1, ADDR_KEY, 32'haa);
    xfer(1'b1, ADDR_CTRL, ctrl);
    for (int i = 0; i < 9 && flash_busy !== 1'b1; i++) @(posedge hclk);
    chk("busy raised", 32'h1, {31'h0, flash_busy});
    for (int i = 0; i < 200 && flash_busy !== 1'b0; i++) @(posedge hclk);
    chk("busy cleared", 32'h0, {31'h0, flash_busy});
    xfer(1'b0, ADDR_CTRL, 32'h0);
    chk("start bit", 32'h0, {31'h0, rd[CTRL_START]});
  endtask : start
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_refuse();
    xfer(1'b1, ADDR_CTRL, 32'h4040);
    xfer(1'b1, ADDR_CTRL, 32'hc040);
    repeat (4) @(posedge hclk);
    chk("busy locked", 32'h0, {31'h0, flash_busy});
    xfer(1'b0, 8'h24, 32'h0);
    chk("unmapped", 32'h0, rd);
    xfer(1'b0, ADDR_KEY, 32'h0);
    chk("key hidden", 32'h0, rd);
    $display("test refuse done");
  endtask : t_refuse
  task automatic t_erase();
    xfer(1'b1, ADDR_ROWADR, 32'h40);
    start(32'hc040);
    tbl_rd(16'h40, 1'b0, 32'hffff);
    tbl_rd(16'h7e, 1'b1, 32'hff);
    $display("test erase done");
  endtask : t_erase
  task automatic t_latch();
    tbl_wr(16'h40, 1'b0, 32'h1234);
    tbl_wr(16'h40, 1'b1, 32'h56);
    tbl_wr(16'h42, 1'b0, 32'hbeef);
    tbl_wr(16'h42, 1'b1, 32'ha5);
    xfer(1'b0, ADDR_ROWADR, 32'h0);
    chk("row address", 32'h42, rd);
    tbl_rd(16'h40, 1'b0, 32'hffff);
    xfer(1'b1, ADDR_PAGE, 32'h5a);
    tbl_wr(16'h44, 1'b0, 32'h1111);
    tbl_wrc(16'h45, 32'h0b, 32'hcd);
    xfer(1'b0, ADDR_ROWADU, 32'h0);
    chk("row upper", 32'h5a, rd);
    $display("test latch done");
  endtask : t_latch
  task automatic t_prog();
    start(32'hc000);
    tbl_rd(16'h40, 1'b0, 32'h1234);
    tbl_rd(16'h40, 1'b1, 32'h56);
    tbl_rd(16'h42, 1'b0, 32'hbeef);
    tbl_rd(16'h42, 1'b1, 32'ha5);
    tbl_rd(16'h44, 1'b0, 32'hcd11);
    tbl_rdc(16'h42, 32'h09, 32'hef);
    tbl_rdc(16'h43, 32'h09, 32'hbe);
    tbl_rdc(16'h42, 32'h19, 32'hbe);
    $display("test program done");
  endtask : t_prog
  task automatic t_serial();
    xfer(1'b1, ADDR_ROWADR, 32'h80);
    u_pft_serial_model.send(24'h9c3a71);
    repeat (10) @(posedge hclk);
    chk("data pin", 32'h1, {30'h0, prog_data_line_out, prog_data_line_oe_n});
    tbl_rd(16'h80, 1'b0, 32'h3a71);
    tbl_rd(16'h80, 1'b1, 32'h9c);
    $display("test serial done");
  endtask : t_serial
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_refuse();
    t_erase();
    t_latch();
    t_prog();
    t_serial();
    report_and_stop();
  end
  initial begin
    #100000;
    num_errors++;
    report_and_stop();
  end
endmodule : pft_top_bench
